/* File: hdl/fpl_faceplate.sv */
// Notes on behaviour
// [R01] 48 indicator lamps, each lit while its operand is high.
// [R02] lamps 1-24 drive panel two, lamps 25-48 drive panel three.
// [R03] self-reset lamp behaviour (default) follows the operand directly.
// [R04] latched lamp stays lit until front reset, remote reset or reset operand.
// [R05] three standard control keys, four more when the user option is fitted.
// [R06] each control key drives its active operand while held.
// [R07] control key active operand stretched 100 ms after release.
// [R08] control key press logs an event when enabled; release never does.
// [R09] one front key at a time; others ignored until it is released.
// [R10] twelve user keys, each with an on and an off operand.
// [R11] each user key lamp shows its on operand.
// [R12] disabled user key ignores the button, both operands low.
// [R13] self-reset user key: on while pressed, off is its complement.
// [R14] latched user key: every press toggles on, off is its complement.
// [R15] latched states saved to non-volatile storage and restored at power-up.
// [R16] self-reset on operand extended by the programmed drop-out time.
// [R17] title line plus active line shown while a user key is on.
// [R18] release line shown only on latched on-to-off, never for self-reset.
// [R19] keys synchronised and debounced; one press edge gives one toggle.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fpl_faceplate #(
    parameter int MS_CYCLES = fpl_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]                    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    output      logic [31:0]                   avs_readdata,
    output      logic                          avs_waitrequest,
    // logic engine operands
    input  wire logic [fpl_pkg::LAMPS-1:0]     lampOperand,
    input  wire logic                          lampResetOperand,
    // faceplate pins
    input  wire logic [fpl_pkg::KEY_CH-1:0]    rawKeys,
    // non-volatile storage
    input  wire logic                          nvRestoreValid,
    input  wire logic [fpl_pkg::USER_KEYS-1:0] nvRestoreData,
    output      logic                          nvSaveStrobe,
    output      logic [fpl_pkg::USER_KEYS-1:0] nvSaveData,
    // key operands
    output      logic [fpl_pkg::CTRL_KEYS-1:0] ctrl_key_active,
    output      logic [fpl_pkg::CTRL_KEYS-1:0] ctrlKeyEvent,
    output      logic [fpl_pkg::USER_KEYS-1:0] userKeyOn,
    output      logic [fpl_pkg::USER_KEYS-1:0] userKeyOff,
    output      logic [fpl_pkg::USER_KEYS-1:0] userKeyLamp,
    // lamp panels
    output      logic [fpl_pkg::PANEL-1:0]     panel2Lamp,
    output      logic [fpl_pkg::PANEL-1:0]     panel3Lamp,
    // message selection
    output      logic [3:0]                    msgKey,
    output      fpl_pkg::fpl_msg_t             msgKind,
    // interrupt
    output      logic                          irq
);
    localparam int NG = fpl_pkg::GRANT_KEYS;
    localparam int NU = fpl_pkg::USER_KEYS;
    localparam int NC = fpl_pkg::CTRL_KEYS;
    localparam logic [16:0] MS_LAST   = 17'(MS_CYCLES - 1);
    localparam logic [6:0]  CTRL_DROP = 7'(fpl_pkg::CTRL_DROP_MS);

    // lowest set bit of a key vector
    function automatic logic [4:0] first_set(input logic [NG-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = NG - 1; i >= 0; i--)
            if (v[i])
                idx = 5'(i);
        return idx;
    endfunction : first_set

    function automatic fpl_pkg::fpl_ukey_mode_t uk_mode(input logic [23:0] r, input int i);
        return fpl_pkg::fpl_ukey_mode_t'(r[2*i +: 2]);
    endfunction : uk_mode

    // registers
    logic [47:0]   lampMode;
    logic [23:0]   ukeyMode;
    logic [6:0]    logEn;
    logic [18:0]   intStatus;
    logic [18:0]   intMask;
    logic [15:0]   holdMs [NU];

    logic          busHit;
    logic          wrHit;
    logic          rdHit;
    logic          statusRead;
    logic          remoteReset;
    logic [31:0]   next_readdata;

    logic [16:0]   msCnt;
    logic          msTick;
    fpl_key_if     keyBus ();

    fpl_key_filter u_filter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .rawKeys (rawKeys),
        .keys    (keyBus)
    );

    // one millisecond enable for all timers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            msCnt  <= 17'h00000;
            msTick <= 1'b0;
        end
        else
        begin
            msTick <= (msCnt == MS_LAST);
            msCnt  <= (msCnt == MS_LAST) ? 17'h00000 : msCnt + 17'h00001;
        end
    end
    assign keyBus.msTick = msTick;

    // key arbitration
    logic          fitted;
    logic [NG-1:0] avail;
    logic [NG-1:0] pressNow;
    logic [NG-1:0] pressPrev;
    logic [NG-1:0] rise;
    logic          ownerValid;
    logic [4:0]    ownerIdx;
    logic [NG-1:0] held;
    logic [NG-1:0] heldPrev;
    logic [NG-1:0] accRise;
    logic          frontPrev;
    logic          frontRise;

    assign fitted    = keyBus.clean[fpl_pkg::CH_FIT];
    assign avail     = {{NU{fitted}}, {(NC - fpl_pkg::CTRL_STD){fitted}},
                        {fpl_pkg::CTRL_STD{1'b1}}}; // see [R05]
    assign pressNow  = keyBus.clean[NG-1:0] & avail;
    assign rise      = pressNow & ~pressPrev;
    assign held      = ownerValid ? (pressNow & NG'({{(NG-1){1'b0}}, 1'b1} << ownerIdx))
                                  : '0;
    assign accRise   = held & ~heldPrev; // see [R19]
    assign frontRise = keyBus.clean[fpl_pkg::CH_FRONT_RST] & ~frontPrev;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pressPrev <= '0;
            heldPrev  <= '0;
            frontPrev <= 1'b0;
        end
        else
        begin
            pressPrev <= pressNow;
            heldPrev  <= held;
            frontPrev <= keyBus.clean[fpl_pkg::CH_FRONT_RST];
        end
    end

    // a key held across the owner's release needs a fresh edge to be taken
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ownerValid <= 1'b0;
            ownerIdx   <= 5'h00;
        end
        else if (ownerValid)
        begin
            if (!pressNow[ownerIdx])
                ownerValid <= 1'b0; // see [R09]
        end
        else if (|rise)
        begin
            ownerValid <= 1'b1;
            ownerIdx   <= first_set(rise); // see [R09]
        end
    end

    // control keys
    logic [6:0]    ctrlCnt [NC];
    logic [NC-1:0] next_ctrlActive;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            for (int i = 0; i < NC; i++)
                ctrlCnt[i] <= 7'h00;
        else
            for (int i = 0; i < NC; i++)
                if (held[i])
                    ctrlCnt[i] <= CTRL_DROP; // see [R07]
                else if (msTick && ctrlCnt[i] != 7'h00)
                    ctrlCnt[i] <= ctrlCnt[i] - 7'h01;
    end

    always_comb
    begin
        for (int i = 0; i < NC; i++)
            next_ctrlActive[i] = held[i] || ctrlCnt[i] != 7'h00; // see [R06] see [R07]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_key_active <= '0;
            ctrlKeyEvent    <= '0;
        end
        else
        begin
            ctrl_key_active <= next_ctrlActive;
            ctrlKeyEvent    <= accRise[NC-1:0] & logEn; // see [R08]
        end
    end

    // user keys
    logic [NU-1:0] userHeld;
    logic [NU-1:0] userAcc;
    logic [15:0]   holdCnt [NU];
    logic [NU-1:0] latchState;
    logic [NU-1:0] next_latch;
    logic [NU-1:0] next_on;
    logic [NU-1:0] next_off;
    logic [NU-1:0] latchedMask;
    logic [NU-1:0] toggles;

    assign userHeld = held[NG-1:NC];
    assign userAcc  = accRise[NG-1:NC];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            for (int i = 0; i < NU; i++)
                holdCnt[i] <= 16'h0000;
        else
            for (int i = 0; i < NU; i++)
                if (userHeld[i])
                    holdCnt[i] <= holdMs[i]; // see [R16]
                else if (msTick && holdCnt[i] != 16'h0000)
                    holdCnt[i] <= holdCnt[i] - 16'h0001;
    end

    always_comb
    begin
        for (int i = 0; i < NU; i++)
        begin
            latchedMask[i] = uk_mode(ukeyMode, i) == fpl_pkg::FPL_UKEY_LATCHED;
            toggles[i]     = userAcc[i] && latchedMask[i];
            next_latch[i]  = nvRestoreValid ? nvRestoreData[i] // see [R15]
                                            : latchState[i] ^ toggles[i]; // see [R14]
            next_on[i]     = 1'b0;
            next_off[i]    = 1'b0;
            case (uk_mode(ukeyMode, i))
                fpl_pkg::FPL_UKEY_SELF:
                begin
                    next_on[i]  = userHeld[i] || holdCnt[i] != 16'h0000; // see [R13] see [R16]
                    next_off[i] = !next_on[i];
                end
                fpl_pkg::FPL_UKEY_LATCHED:
                begin
                    next_on[i]  = next_latch[i]; // see [R14]
                    next_off[i] = !next_latch[i];
                end
                default:
                begin
                    next_on[i]  = 1'b0; // see [R12]
                    next_off[i] = 1'b0;
                end
            endcase
        end
    end

    // latched states leave the block on every change except a restore, so storage can follow
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            latchState   <= '0;
            nvSaveStrobe <= 1'b0;
            nvSaveData   <= '0;
        end
        else
        begin
            latchState   <= next_latch;
            nvSaveStrobe <= (next_latch != latchState) && !nvRestoreValid; // see [R15]
            nvSaveData   <= next_latch;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            userKeyOn   <= '0;
            userKeyOff  <= '0;
            userKeyLamp <= '0;
        end
        else
        begin
            userKeyOn   <= next_on; // see [R10]
            userKeyOff  <= next_off;
            userKeyLamp <= next_on; // see [R11]
        end
    end

    // messages: text lives in the display, the block picks key and line
    logic [NU-1:0] onRise;
    logic [NU-1:0] onFall;

    assign onRise = next_on & ~userKeyOn;
    assign onFall = ~next_on & userKeyOn;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            msgKey  <= 4'h0;
            msgKind <= fpl_pkg::FPL_MSG_NONE;
        end
        else if (|onRise)
        begin
            msgKey  <= 4'(first_set(NG'(onRise))); // see [R17]
            msgKind <= fpl_pkg::FPL_MSG_ACTIVE;
        end
        else if (|(onFall & latchedMask))
        begin
            msgKey  <= 4'(first_set(NG'(onFall & latchedMask)));
            msgKind <= fpl_pkg::FPL_MSG_RELEASE; // see [R18]
        end
        else if (onFall[msgKey])
            msgKind <= fpl_pkg::FPL_MSG_NONE; // see [R18]
    end

    // indicator lamps
    logic [47:0]   lampLatch;
    logic [47:0]   next_lampLatch;
    logic [47:0]   next_lamp;
    logic          lampClr;

    assign lampClr        = frontRise || remoteReset || lampResetOperand; // see [R04]
    assign next_lampLatch = (lampLatch & ~{48{lampClr}}) | lampOperand; // see [R04]
    assign next_lamp      = (lampMode & next_lampLatch) | (~lampMode & lampOperand); // see [R01] see [R03]

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lampLatch  <= '0;
            panel2Lamp <= '0;
            panel3Lamp <= '0;
        end
        else
        begin
            lampLatch  <= next_lampLatch;
            panel2Lamp <= next_lamp[fpl_pkg::PANEL-1:0]; // see [R02]
            panel3Lamp <= next_lamp[fpl_pkg::LAMPS-1:fpl_pkg::PANEL]; // see [R02]
        end
    end

    // bus slave: one wait state, access completes where waitrequest is low
    assign busHit      = (avs_read || avs_write) && !avs_waitrequest;
    assign wrHit       = busHit && avs_write;
    assign rdHit       = busHit && avs_read;
    assign statusRead  = rdHit && avs_address[7:2] == fpl_pkg::OFS_INT_STATUS[7:2];
    assign remoteReset = wrHit && avs_address[7:2] == fpl_pkg::OFS_LAMP_RESET[7:2]
                         && avs_writedata[0];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else if (avs_waitrequest && (avs_read || avs_write))
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always_comb
    begin
        next_readdata = 32'h00000000;
        case (avs_address[7:2])
            fpl_pkg::OFS_LAMP_MODE_LO[7:2]:  next_readdata = lampMode[31:0];
            fpl_pkg::OFS_LAMP_MODE_HI[7:2]:  next_readdata = {16'h0000, lampMode[47:32]};
            fpl_pkg::OFS_UKEY_MODE[7:2]:     next_readdata = {8'h00, ukeyMode};
            fpl_pkg::OFS_CTRL_LOG_EN[7:2]:   next_readdata = {25'h0000000, logEn};
            fpl_pkg::OFS_INT_STATUS[7:2]:    next_readdata = {13'h0000, intStatus};
            fpl_pkg::OFS_INT_MASK[7:2]:      next_readdata = {13'h0000, intMask};
            fpl_pkg::OFS_KEY_STATE[7:2]:
                next_readdata = {12'h000, fitted, userKeyOn, ctrl_key_active};
            fpl_pkg::OFS_LAMP_STATE_LO[7:2]: next_readdata = {panel3Lamp[7:0], panel2Lamp};
            fpl_pkg::OFS_LAMP_STATE_HI[7:2]: next_readdata = {16'h0000, panel3Lamp[23:8]};
            default:
            begin
                if (avs_address >= fpl_pkg::OFS_HOLD_BASE
                    && avs_address <= fpl_pkg::OFS_HOLD_LAST)
                    next_readdata = {16'h0000, holdMs[4'(avs_address[7:2] - 6'h10)]};
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            avs_readdata <= 32'h00000000;
        else if (avs_waitrequest && avs_read)
            avs_readdata <= next_readdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lampMode <= fpl_pkg::LAMP_MODE_RST;
            ukeyMode <= fpl_pkg::UKEY_MODE_RST;
            logEn    <= fpl_pkg::LOG_EN_RST;
            intMask  <= fpl_pkg::MASK_RST;
            for (int i = 0; i < NU; i++)
                holdMs[i] <= fpl_pkg::HOLD_RST;
        end
        else if (wrHit)
        begin
            case (avs_address[7:2])
                fpl_pkg::OFS_LAMP_MODE_LO[7:2]: lampMode[31:0]  <= avs_writedata;
                fpl_pkg::OFS_LAMP_MODE_HI[7:2]: lampMode[47:32] <= avs_writedata[15:0];
                fpl_pkg::OFS_UKEY_MODE[7:2]:    ukeyMode        <= avs_writedata[23:0];
                fpl_pkg::OFS_CTRL_LOG_EN[7:2]:  logEn           <= avs_writedata[6:0];
                fpl_pkg::OFS_INT_MASK[7:2]:     intMask         <= avs_writedata[18:0];
                default:
                begin
                    if (avs_address >= fpl_pkg::OFS_HOLD_BASE
                        && avs_address <= fpl_pkg::OFS_HOLD_LAST)
                        holdMs[4'(avs_address[7:2] - 6'h10)] <= avs_writedata[15:0];
                end
            endcase
        end
    end

    // sticky events: a read clears only the bits it returned, so no event is lost
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            intStatus <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            intStatus <= (intStatus & ~(avs_readdata[18:0] & {19{statusRead}}))
                         | {toggles, accRise[NC-1:0] & logEn}; // see [R08]
            irq       <= |(intStatus & intMask);
        end
    end
endmodule : fpl_faceplate

/* File: hdl/fpl_pkg.sv */
package fpl_pkg;
    // clock and time base
    localparam int CLK_HZ       = 125_000_000;
    localparam int MS_CYCLES    = CLK_HZ / 1000;
    localparam int CTRL_DROP_MS = 100;
    localparam int DEBOUNCE_MS  = 5;

    // sizes
    localparam int LAMPS      = 48;
    localparam int PANEL      = 24;
    localparam int CTRL_KEYS  = 7;
    localparam int CTRL_STD   = 3;
    localparam int USER_KEYS  = 12;
    localparam int GRANT_KEYS = CTRL_KEYS + USER_KEYS;
    localparam int EVT_BITS   = GRANT_KEYS;

    // raw key channel positions
    localparam int CH_USER      = 7;
    localparam int CH_FRONT_RST = 19;
    localparam int CH_FIT       = 20;
    localparam int KEY_CH       = 21;

    // register byte offsets
    localparam logic [7:0] OFS_LAMP_MODE_LO  = 8'h00;
    localparam logic [7:0] OFS_LAMP_MODE_HI  = 8'h04;
    localparam logic [7:0] OFS_LAMP_RESET    = 8'h08;
    localparam logic [7:0] OFS_UKEY_MODE     = 8'h0c;
    localparam logic [7:0] OFS_CTRL_LOG_EN   = 8'h10;
    localparam logic [7:0] OFS_INT_STATUS    = 8'h14;
    localparam logic [7:0] OFS_INT_MASK      = 8'h18;
    localparam logic [7:0] OFS_KEY_STATE     = 8'h1c;
    localparam logic [7:0] OFS_LAMP_STATE_LO = 8'h20;
    localparam logic [7:0] OFS_LAMP_STATE_HI = 8'h24;
    localparam logic [7:0] OFS_HOLD_BASE     = 8'h40;
    localparam logic [7:0] OFS_HOLD_LAST     = 8'h6c;

    // field positions
    localparam int KS_USER_POS = 7;
    localparam int KS_FIT_POS  = 19;

    // values after reset
    localparam logic [47:0] LAMP_MODE_RST = 48'h0;
    localparam logic [23:0] UKEY_MODE_RST = 24'h0;
    localparam logic [6:0]  LOG_EN_RST    = 7'h7f;
    localparam logic [18:0] MASK_RST      = 19'h0;
    localparam logic [15:0] HOLD_RST      = 16'h0;

    typedef enum logic [1:0] {
        FPL_UKEY_DISABLED = 2'h0,
        FPL_UKEY_SELF     = 2'h1,
        FPL_UKEY_LATCHED  = 2'h2
    } fpl_ukey_mode_t;

    typedef enum logic [1:0] {
        FPL_MSG_NONE    = 2'h0,
        FPL_MSG_ACTIVE  = 2'h1,
        FPL_MSG_RELEASE = 2'h2
    } fpl_msg_t;
endpackage : fpl_pkg

/* File: hdl/fpl_key_if.sv */
`timescale 1ns/1ps
interface fpl_key_if;
    logic                        msTick;
    logic [fpl_pkg::KEY_CH-1:0]  clean;

    modport filt (input msTick, output clean);
    modport core (output msTick, input clean);
endinterface : fpl_key_if

/* File: hdl/fpl_key_filter.sv */
`timescale 1ns/1ps
module fpl_key_filter #(
    parameter int DEB_MS = fpl_pkg::DEBOUNCE_MS
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // raw pins
    input  wire logic [fpl_pkg::KEY_CH-1:0] rawKeys,
    // filtered levels
    fpl_key_if.filt                         keys
);
    localparam int N = fpl_pkg::KEY_CH;
    localparam logic [7:0] DEB_LAST = 8'(DEB_MS - 1);

    logic [N-1:0] syncA;
    logic [N-1:0] syncB;
    logic [7:0]   stableCnt [N];

    // two flops before anything looks at the pins
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            syncA <= '0;
            syncB <= '0;
        end
        else
        begin
            syncA <= rawKeys;
            syncB <= syncA;
        end
    end

    // a level change must hold for the whole debounce time; bounces restart it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            keys.clean <= '0;
            for (int i = 0; i < N; i++)
                stableCnt[i] <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (syncB[i] == keys.clean[i])
                    stableCnt[i] <= 8'h00; // see [R19]
                else if (keys.msTick)
                begin
                    if (stableCnt[i] == DEB_LAST)
                    begin
                        keys.clean[i] <= syncB[i]; // see [R19]
                        stableCnt[i]  <= 8'h00;
                    end
                    else
                        stableCnt[i] <= stableCnt[i] + 8'h01;
                end
            end
        end
    end
endmodule : fpl_key_filter

/* File: sim/fpl_nv_model.sv */
`timescale 1ns/1ps
module fpl_nv_model (
    // save side
    input  wire logic        clk,
    input  wire logic        saveStrobe,
    input  wire logic [11:0] saveData,
    // restore side
    input  wire logic        restoreReq,
    output      logic        restoreValid = 1'b0,
    output      logic [11:0] restoreData = 12'h0
);
    logic [11:0] cells = 12'h0;
    // cells survive the block's reset, as storage must
    always @(posedge clk)
    begin
        if (saveStrobe)
            cells <= saveData;
        restoreValid <= restoreReq;
        // data is only valid with the strobe, so show junk otherwise
        restoreData <= restoreReq ? cells : ~restoreData;
    end
endmodule : fpl_nv_model

/* File: sim/fpl_faceplate_sva.sv */
`timescale 1ns/1ps
module fpl_faceplate_sva #(
    parameter int MS_CYCLES = fpl_pkg::MS_CYCLES
) (
    // clock, reset, bus
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    // operands and lamps
    input wire logic [47:0] lampOperand,
    input wire logic [23:0] panel2Lamp,
    input wire logic [23:0] panel3Lamp,
    input wire logic [6:0]  ctrl_key_active,
    input wire logic [6:0]  ctrlKeyEvent,
    input wire logic [11:0] userKeyOn,
    input wire logic [11:0] userKeyOff,
    input wire logic [11:0] userKeyLamp,
    input wire logic        nvSaveStrobe,
    input wire logic [11:0] nvSaveData
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_req |=> s_ans)
        else $error("bus answer wrong");
    AST_LAMP_LIT: assert property (1 |=> ($past(lampOperand) & ~{panel3Lamp, panel2Lamp}) == 0)
        else $error("lamp not lit");
    AST_KEY_LAMP: assert property (userKeyLamp == userKeyOn)
        else $error("key lamp differs");
    AST_ON_OFF: assert property ((userKeyOn & userKeyOff) == 0)
        else $error("on and off together");
    AST_EVT_PULSE: assert property (|ctrlKeyEvent |=> ctrlKeyEvent == 0)
        else $error("event not a pulse");
    AST_EVT_ONE: assert property ($onehot0(ctrlKeyEvent))
        else $error("two events");
    AST_EVT_ACTIVE: assert property (|ctrlKeyEvent |-> ##[0:2] |ctrl_key_active)
        else $error("event without press");
    AST_SAVE_CHANGE: assert property (nvSaveStrobe |-> nvSaveData != $past(nvSaveData))
        else $error("save without change");
endmodule : fpl_faceplate_sva

bind fpl_faceplate fpl_faceplate_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.clk, .sys_rst,
    .avs_read, .avs_write, .avs_waitrequest, .lampOperand, .panel2Lamp, .panel3Lamp,
    .ctrl_key_active, .ctrlKeyEvent, .userKeyOn, .userKeyOff, .userKeyLamp,
    .nvSaveStrobe, .nvSaveData);

/* File: sim/test_faceplate_button_led_logic.sv */
`timescale 1ns/1ps
module test_faceplate_button_led_logic;
    logic        clk = 0, sysRst = 1, rd = 0, wr = 0, lampRst = 0, rReq = 0;
    logic        wt, nvValid, nvStrobe, irq;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, q, rnd = 32'ha433a4ca;
    logic [47:0] lampOp = 48'h0;
    logic [20:0] rawKeys = 21'h100000;
    logic [11:0] nvData, nvSave, uOn, uOff, uLamp;
    logic [6:0]  cAct, cEvt;
    logic [23:0] p2, p3;
    logic [3:0]  msgKey;
    fpl_pkg::fpl_msg_t msgKind;
    int          err_total = 0, checks_done = 0, evCnt = 0, cyc = 0;

    fpl_faceplate #(.MS_CYCLES(10)) u_dut (.clk(clk), .sys_rst(sysRst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wt), .lampOperand(lampOp), .lampResetOperand(lampRst),
        .rawKeys(rawKeys), .nvRestoreValid(nvValid), .nvRestoreData(nvData),
        .nvSaveStrobe(nvStrobe), .nvSaveData(nvSave), .ctrl_key_active(cAct),
        .ctrlKeyEvent(cEvt), .userKeyOn(uOn), .userKeyOff(uOff), .userKeyLamp(uLamp),
        .panel2Lamp(p2), .panel3Lamp(p3), .msgKey(msgKey), .msgKind(msgKind), .irq(irq));
    fpl_nv_model u_nv (.clk(clk), .saveStrobe(nvStrobe), .saveData(nvSave),
        .restoreReq(rReq), .restoreValid(nvValid), .restoreData(nvData));

    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (|cEvt)
            evCnt <= evCnt + 1;
        if (cyc == 40000)
        begin
            err_total++;
            final_report();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1)
        begin
            $display("CHECK FAILED %0t %s", $time, m);
            err_total++;
        end
    endtask : chk

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc

    // waits on waitrequest, never on a fixed latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdata;
        rd <= 0;
        wr <= 0;
        waitc(1);
    endtask : bus

    // 80 cycles covers sync plus 5 ms debounce at 10 cycles a ms
    task automatic key(input int ch, input logic v);
        rawKeys[ch] <= v;
        waitc(80);
    endtask : key

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        waitc(3);
        sysRst <= 0;
        waitc(1);
        bus(0, 8'h10, 0);
        chk(q === 32'h7f, "log enable reset");
        bus(0, 8'hfc, 0);
        chk(q === 32'h0, "unmapped read");
        for (int i = 0; i < 20; i++)
        begin
            rnd = lfsr(rnd);
            lampOp <= {rnd[15:0], lfsr(rnd)};
            waitc(2);
            chk({p3, p2} === lampOp, "lamp follow");
        end
        bus(1, 8'h00, 32'hffffffff);
        lampOp <= 48'h1;
        waitc(2);
        lampOp <= 48'h0;
        waitc(3);
        chk(p2[0] === 1'b1, "latched hold");
        bus(1, 8'h08, 1);
        waitc(2);
        chk(p2[0] === 1'b0, "remote reset");
        lampOp <= 48'h1;
        waitc(2);
        lampOp <= 48'h0;
        lampRst <= 1;
        waitc(2);
        lampRst <= 0;
        chk(p2[0] === 1'b0, "operand reset");
        key(0, 1);
        chk(cAct[0] === 1'b1 && evCnt == 1, "ctrl press");
        key(1, 1);
        chk(cAct[1] === 1'b0, "second key");
        key(1, 0);
        key(0, 0);
        waitc(400);
        chk(cAct[0] === 1'b1, "stretch");
        waitc(700);
        chk(cAct === 7'h0 && evCnt == 1, "dropout");
        key(20, 0);
        key(3, 1);
        chk(cAct[3] === 1'b0, "unfitted key");
        key(3, 0);
        key(2, 1);
        chk(cAct[2] === 1'b1, "standard key");
        key(2, 0);
        key(20, 1);
        bus(1, 8'h0c, 6);
        bus(1, 8'h18, 32'h80);
        key(7, 1);
        key(7, 0);
        chk(uOn[0] === 1'b1 && uOff[0] === 1'b0 && irq === 1'b1, "latch on");
        chk(msgKind === fpl_pkg::FPL_MSG_ACTIVE && msgKey === 4'h0, "msg on");
        bus(0, 8'h14, 0);
        chk(q[7] === 1'b1, "status set");
        bus(0, 8'h14, 0);
        chk(q[7] === 1'b0 && irq === 1'b0, "status clear");
        sysRst <= 1;
        waitc(2);
        sysRst <= 0;
        waitc(1);
        bus(1, 8'h0c, 6);
        bus(1, 8'h44, 20);
        rReq <= 1;
        waitc(1);
        rReq <= 0;
        waitc(4);
        chk(uOn[0] === 1'b1, "restore");
        key(7, 1);
        key(7, 0);
        chk(uOff[0] === 1'b1 && msgKind === fpl_pkg::FPL_MSG_RELEASE, "latch off");
        key(8, 1);
        chk(uOn[1] === 1'b1 && uOff[1] === 1'b0, "self on");
        rawKeys[8] <= 0;
        waitc(130);
        chk(uOn[1] === 1'b1, "hold extension");
        waitc(250);
        chk(uOff[1] === 1'b1 && msgKind === fpl_pkg::FPL_MSG_NONE, "self off");
        key(9, 1);
        chk(uOn[2] === 1'b0 && uOff[2] === 1'b0, "disabled");
        key(9, 0);
        final_report();
    end
endmodule : test_faceplate_button_led_logic
